// ===== hdl/lbe_core.sv
// Ladder boolean executor: one program step per cycle
//
// Function
// - A logic block runs from a load up to the next load.
// - Series merge ANDs current result with newest saved block result.
// - Parallel merge ORs current result with newest saved block result.
// - Merge count must equal load count minus one (minus two for a latch), else error.
// - Merges chain or stack, consuming saved results newest first.
// - Stacked loads before series merges: at most eight pending.
// - Stacked loads before parallel merges: at most eight pending.
// - Condition invert step passes the complement onward.
// - Invert step must be followed by an output step; a NOP step right after the invert ends the check without error.
// - Rising pulse step gives one scan on off-to-on.
// - Falling pulse step gives one scan on on-to-off.
// - Pulse edges also depend on enclosing section being active.
// - Coil write stores the condition every execution, on or off.
// - Inverted coil write stores the complemented condition.
// - Immediate prefix also refreshes the built-in output terminal.
// - Set and reset change the bit only while input is on.
// - Sixteen temporary bits, written by coil, read by load.
// - Temporary bits may be used in any index order.
// - Latching relay step holds its operand bit.
// - Latch with set and reset both on drives bit off.
`timescale 1ns/10ps
`default_nettype none
module lbe_core #(
    parameter int ADDR_W = lbe_pkg::ADDR_W
) (
    input  wire logic                     mclk,
    input  wire logic                     nrst,
    input  wire logic                     step_valid,
    input  wire logic [lbe_pkg::OPC_W-1:0] step_op,
    input  wire logic [ADDR_W-1:0]        step_addr,
    input  wire logic                     step_imm,
    input  wire logic                     section_on,
    input  wire logic                     mem_rd_bit,
    output logic [ADDR_W-1:0]             mem_addr,
    output logic                          mem_wr,
    output logic                          mem_wr_bit,
    output logic                          term_wr,
    output logic [ADDR_W-1:0]             term_addr,
    output logic                          term_bit,
    output logic                          cond,
    output logic                          prog_err,
    output logic                          scan_done
);
    // ==========================================================
    // Reset release
    logic rst_s1_reg;
    logic rst_n;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_s1_reg <= 1'b0;
            rst_n      <= 1'b0;
        end
        else
        begin
            rst_s1_reg <= 1'b1;
            rst_n      <= rst_s1_reg;
        end
    end

    // ==========================================================
    // Step decode
    lbe_pkg::lbe_op_e op;
    assign op = lbe_pkg::lbe_op_e'(step_op);

    logic is_load;
    logic is_merge;
    logic is_out;
    logic is_series;
    logic is_par;
    logic is_pulse;
    logic rd_bit;

    assign is_load   = step_valid && (op == lbe_pkg::LBE_OP_LOAD
                    || op == lbe_pkg::LBE_OP_LOADN
                    || op == lbe_pkg::LBE_OP_TRLOAD
                    || op == lbe_pkg::LBE_OP_TRLOADN);
    assign is_series = step_valid && op == lbe_pkg::LBE_OP_SMERGE;
    assign is_par    = step_valid && op == lbe_pkg::LBE_OP_PMERGE;
    assign is_merge  = is_series || is_par;
    assign is_pulse  = step_valid && (op == lbe_pkg::LBE_OP_UP
                    || op == lbe_pkg::LBE_OP_DOWN);
    assign is_out    = step_valid && (op == lbe_pkg::LBE_OP_COIL
                    || op == lbe_pkg::LBE_OP_COILN
                    || op == lbe_pkg::LBE_OP_SET
                    || op == lbe_pkg::LBE_OP_RESET
                    || op == lbe_pkg::LBE_OP_LATCH
                    || op == lbe_pkg::LBE_OP_TRCOIL);

    // ==========================================================
    // Temporary condition bits
    logic [lbe_pkg::TMP_COUNT-1:0] tmp_reg;
    logic [lbe_pkg::TMP_W-1:0]     tmp_idx;
    assign tmp_idx = step_addr[lbe_pkg::TMP_W-1:0];
    assign rd_bit  = (op == lbe_pkg::LBE_OP_TRLOAD
                   || op == lbe_pkg::LBE_OP_TRLOADN)
                   ? tmp_reg[tmp_idx] : mem_rd_bit;

    // ==========================================================
    // Condition, saved block stack and pulse bank
    logic cond_reg;
    logic cond_next;
    logic first_reg;
    logic top_val;
    logic st_empty;
    logic st_full;
    logic push;
    logic pop;
    logic rise;
    logic fall;
    logic scan_end;

    assign scan_end = step_valid && op == lbe_pkg::LBE_OP_END;
    assign push = is_load && !first_reg;
    assign pop  = is_merge;

    // Current block sits in cond_reg, so seven saved make eight pending
    lbe_block_stack #(.DEPTH(lbe_pkg::STACK_D - 1)) u_stack (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .clear    (scan_end || is_out),
        .push     (push),
        .push_val (cond_reg),
        .pop      (pop),
        .top_val  (top_val),
        .empty    (st_empty),
        .full     (st_full)
    );

    lbe_pulse_bank #(.N(lbe_pkg::PULSE_N)) u_pulse (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .eval       (is_pulse),
        .idx        (step_addr[lbe_pkg::PIDX_W-1:0]),
        .cond_in    (cond_reg),
        .section_on (section_on),
        .rise       (rise),
        .fall       (fall)
    );

    always_comb
    begin
        cond_next = cond_reg;
        if (step_valid)
        begin
            case (op)
                lbe_pkg::LBE_OP_LOAD:    cond_next = rd_bit;
                lbe_pkg::LBE_OP_TRLOAD:  cond_next = rd_bit;
                lbe_pkg::LBE_OP_LOADN:   cond_next = ~rd_bit;
                lbe_pkg::LBE_OP_TRLOADN: cond_next = ~rd_bit;
                lbe_pkg::LBE_OP_AND:     cond_next = cond_reg & mem_rd_bit;
                lbe_pkg::LBE_OP_ANDN:    cond_next = cond_reg & ~mem_rd_bit;
                lbe_pkg::LBE_OP_OR:      cond_next = cond_reg | mem_rd_bit;
                lbe_pkg::LBE_OP_ORN:     cond_next = cond_reg | ~mem_rd_bit;
                lbe_pkg::LBE_OP_SMERGE:  cond_next = cond_reg & top_val;
                lbe_pkg::LBE_OP_PMERGE:  cond_next = cond_reg | top_val;
                lbe_pkg::LBE_OP_INVERT:  cond_next = ~cond_reg;
                lbe_pkg::LBE_OP_UP:      cond_next = rise;
                lbe_pkg::LBE_OP_DOWN:    cond_next = fall;
                default:                 cond_next = cond_reg;
            endcase
        end
    end

    // ==========================================================
    // Program check
    logic [lbe_pkg::CNT_W-1:0] loads_reg;
    logic [lbe_pkg::CNT_W-1:0] merges_reg;
    logic inv_pend_reg;
    logic err_reg;
    logic bad_inv;
    logic bad_merge;
    logic bad_depth;
    logic bad_count;
    logic [lbe_pkg::CNT_W-1:0] blk_need;

    assign bad_inv   = inv_pend_reg && step_valid && !is_out
                     && op != lbe_pkg::LBE_OP_NOP;
    assign bad_merge = is_merge && st_empty;
    assign bad_depth = push && st_full;
    // Latch rung holds two blocks, set and reset, so one merge fewer
    assign blk_need  = (op == lbe_pkg::LBE_OP_LATCH) ? 5'h2 : 5'h1;
    assign bad_count = is_out && (loads_reg != 5'h0)
                     && (merges_reg + blk_need != loads_reg);

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            loads_reg    <= 5'h00;
            merges_reg   <= 5'h00;
            inv_pend_reg <= 1'b0;
            err_reg      <= 1'b0;
        end
        else
        begin
            loads_reg    <= (scan_end || is_out) ? 5'h00
                          : loads_reg + {4'h0, is_load};
            merges_reg   <= (scan_end || is_out) ? 5'h00
                          : merges_reg + {4'h0, is_merge};
            inv_pend_reg <= step_valid ? (op == lbe_pkg::LBE_OP_INVERT)
                          : inv_pend_reg;
            // Sticky until reset so a scan's error is not missed
            err_reg      <= err_reg || bad_inv || bad_merge
                          || bad_depth || bad_count;
        end
    end

    // ==========================================================
    // Outputs to memory and terminal
    logic       wr_next;
    logic       wbit_next;
    logic       mem_wr_reg;
    logic       mem_bit_reg;
    logic       term_wr_reg;
    logic [ADDR_W-1:0] waddr_reg;

    always_comb
    begin
        wr_next   = 1'b0;
        wbit_next = cond_reg;
        case (op)
            lbe_pkg::LBE_OP_COIL:  wr_next = step_valid;
            lbe_pkg::LBE_OP_COILN:
            begin
                wr_next   = step_valid;
                wbit_next = ~cond_reg;
            end
            lbe_pkg::LBE_OP_SET:   wr_next = step_valid && cond_reg;
            lbe_pkg::LBE_OP_RESET:
            begin
                wr_next   = step_valid && cond_reg;
                wbit_next = 1'b0;
            end
            // latch: set input saved, reset is condition
            lbe_pkg::LBE_OP_LATCH:
            begin
                wr_next   = step_valid && (cond_reg || top_val);
                wbit_next = ~cond_reg;
            end
            default:               wr_next = 1'b0;
        endcase
    end

    // temporary bits written only by coil
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            tmp_reg <= '0;
        else if (step_valid && op == lbe_pkg::LBE_OP_TRCOIL)
            tmp_reg[tmp_idx] <= cond_reg;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cond_reg    <= 1'b0;
            first_reg   <= 1'b1;
            mem_wr_reg  <= 1'b0;
            mem_bit_reg <= 1'b0;
            term_wr_reg <= 1'b0;
            waddr_reg   <= '0;
        end
        else
        begin
            cond_reg    <= cond_next;
            first_reg   <= (scan_end || is_out) ? 1'b1
                         : (is_load ? 1'b0 : first_reg);
            mem_wr_reg  <= wr_next;
            mem_bit_reg <= wbit_next;
            term_wr_reg <= wr_next && step_imm;
            waddr_reg   <= step_addr;
        end
    end

    // Read address is combinational so operands resolve in the step cycle
    assign mem_addr   = step_addr;
    assign mem_wr     = mem_wr_reg;
    assign mem_wr_bit = mem_bit_reg;
    assign term_wr    = term_wr_reg;
    assign term_addr  = waddr_reg;
    assign term_bit   = mem_bit_reg;
    assign cond       = cond_reg;
    assign prog_err   = err_reg;
    assign scan_done  = scan_end;

    // ==========================================================
    // Checks
    sequence inv_step_s;
        step_valid && op == lbe_pkg::LBE_OP_INVERT;
    endsequence

    invert_value_a: assert property (@(posedge mclk) disable iff (!rst_n)
        inv_step_s |=> cond == !$past(cond_reg))
        else $error("invert step did not complement");
    series_merge_a: assert property (@(posedge mclk) disable iff (!rst_n)
        is_series && !st_empty |=> cond == ($past(cond_reg) & $past(top_val)))
        else $error("series merge result wrong");
    par_merge_a: assert property (@(posedge mclk) disable iff (!rst_n)
        is_par && !st_empty |=> cond == ($past(cond_reg) | $past(top_val)))
        else $error("parallel merge result wrong");
    coil_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
        step_valid && op == lbe_pkg::LBE_OP_COIL
        |=> mem_wr && mem_wr_bit == $past(cond_reg))
        else $error("coil did not write condition");
    coiln_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
        step_valid && op == lbe_pkg::LBE_OP_COILN
        |=> mem_wr && mem_wr_bit == !$past(cond_reg))
        else $error("inverted coil wrong");
    term_refresh_a: assert property (@(posedge mclk) disable iff (!rst_n)
        term_wr |-> mem_wr && term_bit == mem_wr_bit)
        else $error("terminal refresh without memory write");
    set_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        step_valid && op == lbe_pkg::LBE_OP_SET && !cond_reg
        |=> !mem_wr)
        else $error("set wrote with input off");
    latch_reset_a: assert property (@(posedge mclk) disable iff (!rst_n)
        step_valid && op == lbe_pkg::LBE_OP_LATCH && cond_reg && top_val
        |=> mem_wr && !mem_wr_bit)
        else $error("latch reset priority lost");
    depth_error_a: assert property (@(posedge mclk) disable iff (!rst_n)
        push && st_full |=> prog_err)
        else $error("ninth pending load not flagged");
    rise_once_a: assert property (@(posedge mclk) disable iff (!rst_n)
        is_pulse && op == lbe_pkg::LBE_OP_UP && section_on
        ##1 is_pulse && op == lbe_pkg::LBE_OP_UP && $stable(step_addr)
        |-> !cond_next)
        else $error("rising pulse lasted two evaluations");
    count_error_a: assert property (@(posedge mclk) disable iff (!rst_n)
        bad_count |=> prog_err)
        else $error("unbalanced merges not flagged");
endmodule
`default_nettype wire

// ===== hdl/lbe_pkg.sv
// Package: opcodes, field layout and limits of the ladder boolean executor
package lbe_pkg;
    localparam int OPC_W      = 5;
    localparam int ADDR_W     = 8;
    localparam int TMP_W      = 4;
    localparam int TMP_COUNT  = 16;
    localparam int STACK_D    = 8;
    localparam int PULSE_N    = 16;
    localparam int PIDX_W     = 4;
    localparam int CNT_W      = 5;
    localparam logic [9:0] FC_INVERT = 10'h208;
    localparam logic [9:0] FC_UP     = 10'h209;
    localparam logic [9:0] FC_DOWN   = 10'h20A;
    localparam logic [9:0] FC_LATCH  = 10'h00B;

    typedef enum logic [4:0] {
        LBE_OP_NOP     = 5'h00,
        LBE_OP_LOAD    = 5'h01,
        LBE_OP_LOADN   = 5'h02,
        LBE_OP_AND     = 5'h03,
        LBE_OP_ANDN    = 5'h04,
        LBE_OP_OR      = 5'h05,
        LBE_OP_ORN     = 5'h06,
        LBE_OP_SMERGE  = 5'h07,
        LBE_OP_PMERGE  = 5'h08,
        LBE_OP_INVERT  = 5'h09,
        LBE_OP_UP      = 5'h0A,
        LBE_OP_DOWN    = 5'h0B,
        LBE_OP_COIL    = 5'h0C,
        LBE_OP_COILN   = 5'h0D,
        LBE_OP_SET     = 5'h0E,
        LBE_OP_RESET   = 5'h0F,
        LBE_OP_LATCH   = 5'h10,
        LBE_OP_TRLOAD  = 5'h11,
        LBE_OP_TRLOADN = 5'h12,
        LBE_OP_TRCOIL  = 5'h13,
        LBE_OP_END     = 5'h14
    } lbe_op_e;
endpackage

// ===== hdl/lbe_block_stack.sv
// Block stack: saved logic block results, newest first
`timescale 1ns/10ps
`default_nettype none
module lbe_block_stack #(
    parameter int DEPTH = lbe_pkg::STACK_D
) (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic clear,
    input  wire logic push,
    input  wire logic push_val,
    input  wire logic pop,
    output logic      top_val,
    output logic      empty,
    output logic      full
);
    logic [DEPTH-1:0] data_reg;
    logic [3:0]       cnt_reg;

    assign top_val = data_reg[0];
    assign empty   = (cnt_reg == 4'h0);
    assign full    = (cnt_reg == 4'(DEPTH));

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            data_reg <= '0;
            cnt_reg  <= 4'h0;
        end
        else if (clear)
        begin
            cnt_reg <= 4'h0;
        end
        else if (push && !full)
        begin
            data_reg <= {data_reg[DEPTH-2:0], push_val};
            cnt_reg  <= cnt_reg + 4'h1;
        end
        else if (pop && !empty)
        begin
            data_reg <= {1'b0, data_reg[DEPTH-1:1]};
            cnt_reg  <= cnt_reg - 4'h1;
        end
    end
endmodule
`default_nettype wire

// ===== hdl/lbe_pulse_bank.sv
// Pulse bank: previous-input bits for the rising and falling pulse steps
`timescale 1ns/10ps
`default_nettype none
module lbe_pulse_bank #(
    parameter int N = lbe_pkg::PULSE_N
) (
    input  wire logic                      mclk,
    input  wire logic                      rst_n,
    input  wire logic                      eval,
    input  wire logic [lbe_pkg::PIDX_W-1:0] idx,
    input  wire logic                      cond_in,
    input  wire logic                      section_on,
    output logic                           rise,
    output logic                           fall
);
    logic [N-1:0] prev_reg;
    logic         eff_in;
    logic         prev_sel;

    // Inactive section sees its input as off
    assign eff_in   = cond_in & section_on;
    assign prev_sel = prev_reg[idx];
    assign rise     = eff_in & ~prev_sel;
    assign fall     = ~eff_in & prev_sel;

    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_prev
            always_ff @(posedge mclk or negedge rst_n)
            begin
                if (!rst_n)
                    prev_reg[g] <= 1'b0;
                else if (eval && idx == g)
                    prev_reg[g] <= eff_in;
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ===== verif/lbe_io_mem.sv
// Behavioural I/O bit memory seen by the executor core
`timescale 1ns/10ps
`default_nettype none
module lbe_io_mem #(
    parameter int ADDR_W = 8
) (
    input  wire logic              mclk,
    input  wire logic [ADDR_W-1:0] mem_addr,
    input  wire logic              mem_wr,
    input  wire logic              mem_wr_bit,
    input  wire logic [ADDR_W-1:0] term_addr,
    output logic                   mem_rd_bit
);
    logic bits [2**ADDR_W];

    // Even addresses on, odd off, so both input levels are at hand
    initial
    begin
        for (int i = 0; i < 2**ADDR_W; i++)
            bits[i] = ~i[0];
    end

    // Read is combinational: the core samples it in the same cycle
    assign mem_rd_bit = bits[mem_addr];

    // Writes land at the registered address, not the live one
    always @(posedge mclk)
    begin
        if (mem_wr)
            bits[term_addr] <= mem_wr_bit;
    end
endmodule
`default_nettype wire

// ===== verif/lbe_core_tb.sv
// Self-checking bench for the ladder boolean executor core
`timescale 1ns/10ps
`default_nettype none
module lbe_core_tb;
    typedef lbe_pkg::lbe_op_e lbe_opc_e;
    localparam lbe_opc_e op_bl = lbe_pkg::LBE_OP_LOAD,
        op_bln = lbe_pkg::LBE_OP_LOADN, op_sm = lbe_pkg::LBE_OP_SMERGE,
        op_pm = lbe_pkg::LBE_OP_PMERGE, op_inv = lbe_pkg::LBE_OP_INVERT,
        op_up = lbe_pkg::LBE_OP_UP, op_dn = lbe_pkg::LBE_OP_DOWN,
        op_coil = lbe_pkg::LBE_OP_COIL, op_coiln = lbe_pkg::LBE_OP_COILN,
        op_set = lbe_pkg::LBE_OP_SET, op_rst = lbe_pkg::LBE_OP_RESET,
        op_lat = lbe_pkg::LBE_OP_LATCH, op_trl = lbe_pkg::LBE_OP_TRLOAD,
        op_trln = lbe_pkg::LBE_OP_TRLOADN, op_trc = lbe_pkg::LBE_OP_TRCOIL,
        op_end = lbe_pkg::LBE_OP_END, op_nop = lbe_pkg::LBE_OP_NOP;
    // Row flags: imm, section, check cond, cond, check write, write, bit
    localparam logic [6:0] c0 = 7'h30, c1 = 7'h38, nc = 7'h20, s0 = 7'h00;
    localparam logic [6:0] w0 = 7'h26, w1 = 7'h27, nw = 7'h24, wi0 = 7'h66;
    typedef struct packed {
        lbe_opc_e   op;
        logic [7:0] a;
        logic [6:0] f;
    } lbe_row_s;

    logic       mclk, nrst, step_valid, step_imm, section_on, mem_rd_bit;
    logic       mem_wr, mem_wr_bit, term_wr, term_bit, cond, prog_err;
    logic       scan_done;
    logic [4:0] step_op;
    logic [7:0] step_addr, mem_addr, term_addr;
    int         mismatches;
    int         compares;
    lbe_row_s   last;

    lbe_core uut (
        .mclk(mclk), .nrst(nrst), .step_valid(step_valid),
        .step_op(step_op), .step_addr(step_addr), .step_imm(step_imm),
        .section_on(section_on), .mem_rd_bit(mem_rd_bit),
        .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_wr_bit(mem_wr_bit),
        .term_wr(term_wr), .term_addr(term_addr), .term_bit(term_bit),
        .cond(cond), .prog_err(prog_err), .scan_done(scan_done)
    );
    lbe_io_mem io_mem (
        .mclk(mclk), .mem_addr(mem_addr), .mem_wr(mem_wr),
        .mem_wr_bit(mem_wr_bit), .term_addr(term_addr),
        .mem_rd_bit(mem_rd_bit)
    );

    // =====================================================================
    // Rung table: inputs at 00 and 02 are on, 01 and 03 off
    lbe_row_s rows [$] = '{
        '{op_bl,8'h01,c0}, '{op_bl,8'h00,c1}, '{op_sm,8'h00,c0},
        '{op_coil,8'h80,w0}, '{op_bl,8'h01,c0}, '{op_bl,8'h00,c1},
        '{op_pm,8'h00,c1}, '{op_coiln,8'h81,wi0}, '{op_bl,8'h01,c0},
        '{op_bl,8'h00,c1}, '{op_bl,8'h03,c0}, '{op_sm,8'h00,c0},
        '{op_pm,8'h00,c0}, '{op_coil,8'h82,w0}, '{op_bl,8'h00,c1},
        '{op_inv,8'h00,nc}, '{op_coil,8'h84,w0}, '{op_bln,8'h00,c0},
        '{op_inv,8'h00,nc}, '{op_coiln,8'h85,wi0}, '{op_bl,8'h00,c1},
        '{op_trc,8'h05,nc}, '{op_bl,8'h01,c0}, '{op_trc,8'h02,nc},
        '{op_trl,8'h02,c0}, '{op_coil,8'h8A,w0}, '{op_trl,8'h05,c1},
        '{op_coil,8'h8B,w1}, '{op_trln,8'h02,c1}, '{op_coiln,8'h8C,w0},
        '{op_bl,8'h00,c1}, '{op_set,8'h8D,w1}, '{op_bl,8'h01,c0},
        '{op_set,8'h8D,nw}, '{op_bl,8'h00,c1}, '{op_rst,8'h8D,w0},
        '{op_bl,8'h01,c0}, '{op_rst,8'h8D,nw}, '{op_bl,8'h01,c0},
        '{op_up,8'h03,c0}, '{op_coil,8'h86,w0}, '{op_bl,8'h00,c1},
        '{op_up,8'h03,c1}, '{op_coil,8'h86,w1}, '{op_bl,8'h00,c1},
        '{op_up,8'h03,c0}, '{op_coil,8'h86,w0}, '{op_bl,8'h00,c1},
        '{op_up,8'h06,c1}, '{op_coil,8'h88,w1}, '{op_bl,8'h00,c1},
        '{op_dn,8'h04,c0}, '{op_coil,8'h87,w0}, '{op_bl,8'h01,c0},
        '{op_dn,8'h04,c1}, '{op_coil,8'h87,w1}, '{op_bl,8'h01,c0},
        '{op_dn,8'h04,c0}, '{op_coil,8'h87,w0}, '{op_bl,8'h00,s0},
        '{op_up,8'h09,7'h10}, '{op_coil,8'h89,7'h06}, '{op_bl,8'h00,c1},
        '{op_up,8'h09,c1}, '{op_coil,8'h89,w1}, '{op_bl,8'h00,c1},
        '{op_bl,8'h01,c0}, '{op_lat,8'h8E,w1}, '{op_bl,8'h00,c1},
        '{op_bl,8'h00,c1}, '{op_lat,8'h8E,w0}, '{op_bl,8'h01,c0},
        '{op_bl,8'h01,c0}, '{op_lat,8'h8E,nw}
    };

    initial
    begin
        mclk = 1'h0;
        forever #2 mclk = ~mclk;
    end

    // =====================================================================
    // Compare and drive tasks
    task automatic cmp(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: %s is %b", $time, what, got);
        end
    endtask

    task automatic cmp_addr(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: write address %h", $time, got);
        end
    endtask

    task automatic check_row(input lbe_row_s r);
        if (r.f[4])
            cmp(cond, r.f[3], "cond");
        if (r.f[2])
        begin
            cmp(mem_wr, r.f[1], "write strobe");
            cmp(term_wr, r.f[1] & r.f[6], "refresh");
        end
        if (r.f[2] && r.f[1])
        begin
            cmp(mem_wr_bit, r.f[0], "write bit");
            cmp(term_bit, r.f[0], "terminal bit");
            cmp_addr(term_addr, r.a);
        end
    endtask

    // Previous step is judged one edge after it was taken
    task automatic put(input lbe_opc_e op, input logic [7:0] a,
                       input logic [6:0] f);
        @(posedge mclk);
        step_valid <= (op != op_nop);
        step_op <= op;
        step_addr <= a;
        step_imm <= f[6];
        section_on <= f[5];
        #1;
        check_row(last);
        last = '{op, a, f};
    endtask

    task automatic do_reset();
        @(posedge mclk);
        nrst <= 1'h0;
        step_valid <= 1'h0;
        repeat (5) @(posedge mclk);
        #1;
        cmp(cond | mem_wr | term_wr, 1'h0, "outputs in reset");
        cmp(prog_err, 1'h0, "error in reset");
        @(posedge mclk);
        nrst <= 1'h1;
        repeat (2) @(posedge mclk);
        last.f = nc;
    endtask

    // n loads stacked ahead of n-1 merges of one kind
    task automatic stack(input lbe_opc_e mop, input lbe_opc_e fl,
                         input logic [7:0] ra, input int n, input logic eb);
        do_reset();
        put(fl, 8'h00, nc);
        for (int i = 1; i < n; i++)
            put(op_bl, ra, nc);
        for (int i = 1; i < n; i++)
            put(mop, 8'h00, nc);
        put(op_coil, 8'h8F, (n <= 8) ? {6'h13, eb} : nc);
        repeat (3) put(op_nop, 8'h00, nc);
        cmp(prog_err, logic'(n > 8), "stack limit");
        $display("test stack of %0d finished", n);
    endtask

    task automatic bad(input lbe_opc_e x, input lbe_opc_e y);
        do_reset();
        put(op_bl, 8'h00, nc);
        put(x, 8'h00, nc);
        put(y, 8'h00, nc);
        put(op_coil, 8'h90, nc);
        repeat (3) put(op_nop, 8'h00, nc);
        cmp(prog_err, 1'h1, "faulty rung");
        $display("test faulty rung finished");
    endtask

    task automatic conclude();
        $display("counts: %0d compares, %0d mismatches", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // =====================================================================
    // Main sequence
    initial
    begin
        mismatches = 0;
        compares = 0;
        nrst = 1'h0;
        step_valid = 1'h0;
        step_op = 5'h00;
        step_addr = 8'h00;
        step_imm = 1'h0;
        section_on = 1'h1;
        last = '{op_nop, 8'h00, nc};
        do_reset();
        foreach (rows[i])
        begin
            put(rows[i].op, rows[i].a, rows[i].f);
            cmp(prog_err, 1'h0, "error flag");
        end
        repeat (2) put(op_nop, 8'h00, nc);
        $display("test rung table finished");
        stack(op_sm, op_bln, 8'h00, 8, 1'h0);
        stack(op_sm, op_bln, 8'h00, 9, 1'h0);
        stack(op_pm, op_bl, 8'h01, 8, 1'h1);
        stack(op_pm, op_bl, 8'h01, 9, 1'h1);
        bad(op_bl, op_nop);
        bad(op_sm, op_nop);
        bad(op_inv, op_up);
        put(op_end, 8'h00, nc);
        cmp(scan_done, 1'h1, "scan end");
        put(op_nop, 8'h00, nc);
        cmp(scan_done, 1'h0, "scan end");
        $display("test scan end finished");
        conclude();
    end

    // Whole run needs well under a thousand cycles
    initial
    begin
        repeat (4000) @(posedge mclk);
        mismatches++;
        $display("unexpected at %0t: watchdog expired", $time);
        conclude();
    end
endmodule
`default_nettype wire
